// ===== rtl/src_pkg.sv
// Package: register map, field positions, reset values and shared helpers
// of the serial receive control block.
// Assumes a 32-bit APB slave with one aligned word per register.
package src_pkg;

    // ********************************************
    // Register byte offsets
    // ********************************************
    localparam logic [7:0] OFF_RX_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OFF_RX_DATA        = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h0C;
    localparam logic [7:0] OFF_LINK_CFG       = 8'h10;

    // ********************************************
    // Receive status/control fields
    // ********************************************
    localparam int BIT_SERIAL_PORT_ENABLE  = 7;
    localparam int BIT_NINE_BIT_SELECT     = 6;
    localparam int BIT_SINGLE_RECEIVE      = 5;
    localparam int BIT_CONTINUOUS_RECEIVE  = 4;
    localparam int BIT_ADDRESS_DETECT      = 3;
    localparam int BIT_FRAMING_ERROR       = 2;
    localparam int BIT_OVERRUN_ERROR       = 1;
    localparam int BIT_RECEIVED_NINTH      = 0;

    // ********************************************
    // Link configuration and interrupt fields
    // ********************************************
    localparam int BIT_SYNC_MODE   = 16;
    localparam int BIT_SYNC_MASTER = 17;
    localparam int IRQ_RX_CHAR     = 0;
    localparam int IRQ_FRAMING     = 1;
    localparam int IRQ_OVERRUN     = 2;
    localparam int IRQ_WIDTH       = 3;

    // ********************************************
    // Reset values and timing counts
    // ********************************************
    localparam logic [7:0]  RST_RX_STATUS_CTRL = 8'h00;
    localparam logic [15:0] RST_DIVISOR        = 16'h0000;
    localparam logic [2:0]  RST_IRQ_MASK       = 3'h0;
    localparam logic [3:0]  SAMPLE_MID         = 4'h7;
    localparam logic [3:0]  SAMPLE_LAST        = 4'hF;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } src_rx_state_t;

    // Index of the last data bit of a character
    function automatic logic [3:0] last_bit_idx(input logic nine);
        last_bit_idx = nine ? 4'h8 : 4'h7;
    endfunction

endpackage

// ===== rtl/src_async_rx.sv
// Asynchronous character receiver, 16 ticks per bit, LSB first.
// Assumes rxd is already synchronised and tick is a one-cycle enable.
`timescale 1ns/1ps
module src_async_rx (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic       rxd,
    input  wire logic       nine,
    output logic            done_reg,
    output logic [8:0]      data_reg,
    output logic            framing_error_flag_reg
);

    src_pkg::src_rx_state_t state_reg;
    logic [3:0]             tick_cnt_reg;
    logic [3:0]             bit_cnt_reg;
    logic [8:0]             shift_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= src_pkg::RX_IDLE;
            tick_cnt_reg <= 4'h0;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 9'h000;
            done_reg     <= 1'b0;
            data_reg     <= 9'h000;
            framing_error_flag_reg     <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!enable) begin
                state_reg <= src_pkg::RX_IDLE;
            end else begin
                case (state_reg)
                    src_pkg::RX_IDLE: begin
                        tick_cnt_reg <= 4'h0;
                        bit_cnt_reg  <= 4'h0;
                        if (!rxd) begin
                            state_reg <= src_pkg::RX_START;
                        end
                    end
                    src_pkg::RX_START: begin
                        if (tick) begin
                            if (tick_cnt_reg == src_pkg::SAMPLE_MID) begin
                                tick_cnt_reg <= 4'h0;
                                // Glitch shorter than half a bit is dropped
                                state_reg    <= rxd ? src_pkg::RX_IDLE : src_pkg::RX_DATA;
                            end else begin
                                tick_cnt_reg <= tick_cnt_reg + 4'h1;
                            end
                        end
                    end
                    src_pkg::RX_DATA: begin
                        if (tick) begin
                            if (tick_cnt_reg == src_pkg::SAMPLE_LAST) begin
                                tick_cnt_reg <= 4'h0;
                                shift_reg    <= {rxd, shift_reg[8:1]};
                                if (bit_cnt_reg == src_pkg::last_bit_idx(nine)) begin
                                    state_reg <= src_pkg::RX_STOP;
                                end else begin
                                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                end
                            end else begin
                                tick_cnt_reg <= tick_cnt_reg + 4'h1;
                            end
                        end
                    end
                    src_pkg::RX_STOP: begin
                        if (tick) begin
                            if (tick_cnt_reg == src_pkg::SAMPLE_LAST) begin
                                done_reg  <= 1'b1;
                                data_reg  <= nine ? shift_reg : {1'b0, shift_reg[8:1]};
                                framing_error_flag_reg  <= !rxd;
                                state_reg <= src_pkg::RX_IDLE;
                            end else begin
                                tick_cnt_reg <= tick_cnt_reg + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= src_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ===== rtl/src_top.sv
// Serial receive control: APB register file, receive buffer, error flags,
// synchronous receive engine and interrupt logic.
// Assumes pins arrive asynchronously; a remote transmitter drives the data pin.
// Operation
// - Port enable claims data and clock pins; clear holds receiver in reset.
// - Nine-bit select picks nine or eight data bits per character.
// - Sync master: single receive takes one character, then hardware clears it.
// - Async mode: continuous receive bit turns the receiver on and off.
// - Sync mode: continuous receive runs back to back, overriding single receive.
// - Address detect off accepts all characters; ignored in eight-bit async.
// - Framing flag follows the buffered character, renewed on the next character; cleared by port disable.
// - Ninth received bit of buffered character readable; no hardware parity.
// - Control bits and error flags reset to zero at power-on.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module src_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              DATA_PIN_I,
    output logic                   DATA_PIN_O,
    output logic                   DATA_PIN_OE,
    input  wire logic              CLK_PIN_I,
    output logic                   CLK_PIN_O,
    output logic                   CLK_PIN_OE,
    output logic                   PORT_PINS_OWNED,
    output logic                   IRQ
);

    // ********************************************
    // Registers
    // ********************************************
    localparam int        IRQ_W = src_pkg::IRQ_WIDTH;
    logic                 serial_port_enable_reg;
    logic                 rx9_reg;
    logic                 single_receive_enable_reg;
    logic                 continuous_receive_enable_reg;
    logic                 address_detect_enable_reg;
    logic                 framing_error_flag_reg;
    logic                 overrun_error_flag_reg;
    logic                 received_ninth_bit_reg;
    logic [7:0]           buf_data_reg;
    logic                 buf_full_reg;
    logic [IRQ_W-1:0]     irq_st_reg;
    logic [IRQ_W-1:0]     irq_mask_reg;
    logic [15:0]          divisor_reg;
    logic                 sync_reg;
    logic                 master_reg;

    // ********************************************
    // Pin synchronisers
    // ********************************************
    logic [1:0]           data_sync_reg;
    logic [1:0]           clk_sync_reg;
    logic                 clk_prev_reg;
    logic                 rxd;
    logic                 ck_in;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            data_sync_reg <= 2'b11;
            clk_sync_reg  <= 2'b00;
            clk_prev_reg  <= 1'b0;
        end else begin
            data_sync_reg <= {data_sync_reg[0], DATA_PIN_I};
            clk_sync_reg  <= {clk_sync_reg[0], CLK_PIN_I};
            clk_prev_reg  <= clk_sync_reg[1];
        end
    end

    assign rxd   = data_sync_reg[1];
    assign ck_in = clk_sync_reg[1];

    // ********************************************
    // APB decode
    // ********************************************
    logic                 apb_done;
    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic [31:0]          rd_value;

    assign apb_done = PSEL && PENABLE && PREADY;
    assign wr_en    = apb_done && PWRITE;
    assign rd_en    = apb_done && !PWRITE;

    logic wr_ctrl;
    logic rd_data;
    logic rd_ist;
    assign wr_ctrl = wr_en && (PADDR[7:0] == src_pkg::OFF_RX_STATUS_CTRL);
    assign rd_data = rd_en && (PADDR[7:0] == src_pkg::OFF_RX_DATA);
    assign rd_ist  = rd_en && (PADDR[7:0] == src_pkg::OFF_IRQ_STATUS);

    always_comb begin
        addr_ok  = 1'b1;
        rd_value = 32'h0000_0000;
        case (PADDR[7:0])
            src_pkg::OFF_RX_STATUS_CTRL: begin
                rd_value[7:0] = {serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg,
                                 framing_error_flag_reg, overrun_error_flag_reg, received_ninth_bit_reg};
            end
            src_pkg::OFF_RX_DATA: begin
                rd_value[7:0] = buf_data_reg;
            end
            src_pkg::OFF_IRQ_STATUS: begin
                rd_value[IRQ_W-1:0] = irq_st_reg;
            end
            src_pkg::OFF_IRQ_MASK: begin
                rd_value[IRQ_W-1:0] = irq_mask_reg;
            end
            src_pkg::OFF_LINK_CFG: begin
                rd_value[15:0]                   = divisor_reg;
                rd_value[src_pkg::BIT_SYNC_MODE]   = sync_reg;
                rd_value[src_pkg::BIT_SYNC_MASTER] = master_reg;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // One wait state: answer is registered in the first access cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY  <= 1'b1;
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_value;
            PSLVERR <= !addr_ok;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // ********************************************
    // Configuration registers
    // ********************************************
    logic single_receive_enable_hw_clear;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            serial_port_enable_reg  <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_SERIAL_PORT_ENABLE];
            rx9_reg   <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_NINE_BIT_SELECT];
            continuous_receive_enable_reg  <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_CONTINUOUS_RECEIVE];
            address_detect_enable_reg <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_ADDRESS_DETECT];
        end else if (wr_ctrl) begin
            serial_port_enable_reg  <= PWDATA[src_pkg::BIT_SERIAL_PORT_ENABLE];
            rx9_reg   <= PWDATA[src_pkg::BIT_NINE_BIT_SELECT];
            continuous_receive_enable_reg  <= PWDATA[src_pkg::BIT_CONTINUOUS_RECEIVE];
            address_detect_enable_reg <= PWDATA[src_pkg::BIT_ADDRESS_DETECT];
        end
    end

    // Software write wins over the hardware clear
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            single_receive_enable_reg <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_SINGLE_RECEIVE];
        end else if (wr_ctrl) begin
            single_receive_enable_reg <= PWDATA[src_pkg::BIT_SINGLE_RECEIVE];
        end else if (single_receive_enable_hw_clear) begin
            single_receive_enable_reg <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            divisor_reg  <= src_pkg::RST_DIVISOR;
            sync_reg     <= 1'b0;
            master_reg   <= 1'b0;
            irq_mask_reg <= src_pkg::RST_IRQ_MASK;
        end else if (wr_en && PADDR[7:0] == src_pkg::OFF_LINK_CFG) begin
            divisor_reg <= PWDATA[15:0];
            sync_reg    <= PWDATA[src_pkg::BIT_SYNC_MODE];
            master_reg  <= PWDATA[src_pkg::BIT_SYNC_MASTER];
        end else if (wr_en && PADDR[7:0] == src_pkg::OFF_IRQ_MASK) begin
            irq_mask_reg <= PWDATA[IRQ_W-1:0];
        end
    end

    // ********************************************
    // Rate divider
    // ********************************************
    logic [15:0] div_cnt_reg;
    logic        tick;

    assign tick = (div_cnt_reg == divisor_reg);

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_cnt_reg <= 16'h0000;
        end else if (!serial_port_enable_reg || tick) begin
            div_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    // ********************************************
    // Asynchronous receiver
    // ********************************************
    logic       async_done;
    logic [8:0] async_data;
    logic       async_framing_error_flag;
    logic       async_en;

    // Receiver stalls while an overrun stands, as the buffer cannot take more
    assign async_en = serial_port_enable_reg && !sync_reg && continuous_receive_enable_reg && !overrun_error_flag_reg;

    src_async_rx u_async_rx (
        .clk      (SYS_CLK),
        .rst_b    (RST_B),
        .enable   (async_en),
        .tick     (tick),
        .rxd      (rxd),
        .nine     (rx9_reg),
        .done_reg (async_done),
        .data_reg (async_data),
        .framing_error_flag_reg (async_framing_error_flag)
    );

    // ********************************************
    // Synchronous receiver
    // ********************************************
    logic       sync_go;
    logic       sync_edge;
    logic [3:0] sync_cnt_reg;
    logic [8:0] sync_sh_reg;
    logic [8:0] sync_sh_next;
    logic       sync_done_reg;
    logic [8:0] sync_data_reg;

    assign sync_go      = serial_port_enable_reg && sync_reg && !overrun_error_flag_reg
                          && (continuous_receive_enable_reg || (master_reg && single_receive_enable_reg));
    assign sync_edge    = master_reg ? (tick && !CLK_PIN_O) : (ck_in && !clk_prev_reg);
    assign sync_sh_next = {rxd, sync_sh_reg[8:1]};
    assign single_receive_enable_hw_clear = sync_done_reg && !continuous_receive_enable_reg && master_reg;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync_cnt_reg  <= 4'h0;
            sync_sh_reg   <= 9'h000;
            sync_done_reg <= 1'b0;
            sync_data_reg <= 9'h000;
            CLK_PIN_O     <= 1'b0;
        end else begin
            sync_done_reg <= 1'b0;
            if (!sync_go || sync_done_reg && !continuous_receive_enable_reg) begin
                // Single receive ends after one character
                sync_cnt_reg <= 4'h0;
                CLK_PIN_O    <= 1'b0;
            end else begin
                if (master_reg && tick) begin
                    CLK_PIN_O <= !CLK_PIN_O;
                end
                if (sync_edge) begin
                    sync_sh_reg <= sync_sh_next;
                    if (sync_cnt_reg == src_pkg::last_bit_idx(rx9_reg)) begin
                        sync_cnt_reg  <= 4'h0;
                        sync_done_reg <= 1'b1;
                        sync_data_reg <= rx9_reg ? sync_sh_next : {1'b0, sync_sh_next[8:1]};
                    end else begin
                        sync_cnt_reg <= sync_cnt_reg + 4'h1;
                    end
                end
            end
        end
    end

    // ********************************************
    // Receive buffer and error flags
    // ********************************************
    logic       char_done;
    logic [8:0] char_data;
    logic       char_framing_error_flag;
    logic       char_keep;
    logic       overrun_ev;
    logic       load_ev;
    logic       overrun_error_flag_clear;

    assign char_done  = async_done || sync_done_reg;
    assign char_data  = async_done ? async_data : sync_data_reg;
    assign char_framing_error_flag  = async_done && async_framing_error_flag;
    assign char_keep  = !(async_done && rx9_reg && address_detect_enable_reg && !char_data[8]);
    assign overrun_ev = char_done && char_keep && buf_full_reg && !rd_data;
    assign load_ev    = char_done && char_keep && !overrun_ev;
    assign overrun_error_flag_clear = !serial_port_enable_reg || (wr_ctrl && continuous_receive_enable_reg && !PWDATA[src_pkg::BIT_CONTINUOUS_RECEIVE]);

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            buf_full_reg <= 1'b0;
            buf_data_reg <= 8'h00;
            framing_error_flag_reg     <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_FRAMING_ERROR];
            received_ninth_bit_reg     <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_RECEIVED_NINTH];
        end else if (!serial_port_enable_reg) begin
            buf_full_reg <= 1'b0;
            framing_error_flag_reg     <= 1'b0;
        end else if (load_ev) begin
            buf_full_reg <= 1'b1;
            buf_data_reg <= char_data[7:0];
            framing_error_flag_reg     <= char_framing_error_flag;
            received_ninth_bit_reg     <= char_data[8];
        end else if (rd_data) begin
            buf_full_reg <= 1'b0;
        end
    end

    // Overrun set wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            overrun_error_flag_reg <= src_pkg::RST_RX_STATUS_CTRL[src_pkg::BIT_OVERRUN_ERROR];
        end else if (overrun_ev && serial_port_enable_reg) begin
            overrun_error_flag_reg <= 1'b1;
        end else if (overrun_error_flag_clear) begin
            overrun_error_flag_reg <= 1'b0;
        end
    end

    // ********************************************
    // Interrupts and pin outputs
    // ********************************************
    logic [IRQ_W-1:0] irq_ev;

    always_comb begin
        irq_ev                       = '0;
        irq_ev[src_pkg::IRQ_RX_CHAR] = load_ev && serial_port_enable_reg;
        irq_ev[src_pkg::IRQ_FRAMING] = load_ev && serial_port_enable_reg && char_framing_error_flag;
        irq_ev[src_pkg::IRQ_OVERRUN] = overrun_ev && serial_port_enable_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_st_reg <= '0;
            IRQ        <= 1'b0;
        end else begin
            irq_st_reg <= (rd_ist ? '0 : irq_st_reg) | irq_ev;
            IRQ        <= |(irq_st_reg & irq_mask_reg);
        end
    end

    // Receive-only block: the data pin is never driven
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            DATA_PIN_O      <= 1'b0;
            DATA_PIN_OE     <= 1'b0;
            CLK_PIN_OE      <= 1'b0;
            PORT_PINS_OWNED <= 1'b0;
        end else begin
            DATA_PIN_O      <= 1'b0;
            DATA_PIN_OE     <= 1'b0;
            CLK_PIN_OE      <= serial_port_enable_reg && sync_reg && master_reg;
            PORT_PINS_OWNED <= serial_port_enable_reg;
        end
    end

endmodule

// ===== dv/src_tx_model.sv
// Partner: remote asynchronous transmitter on the receive data pin.
// Assumes divisor 0 in the block, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module src_tx_model (
    input  wire logic clk,
    output logic      txd
);
    initial txd = 1'b1;
    // Last clocks high, so a low stop bit cannot pose as a new start
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        logic [10:0] f;
        int          n;
        f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        n = nine ? 176 : 160;
        for (int i = 0; i < n; i++) begin
            txd <= (i >= n - 4) ? 1'b1 : f[i / 16];
            @(posedge clk);
        end
    endtask
endmodule

// ===== dv/src_properties.sv
// Checker: APB and pin relations of src_top, seen at its ports.
// Assumes one clock domain with asynchronous reset RST_B.
`timescale 1ns/1ps
module src_properties #(
    parameter int ADDR_W = 8
) (
    input wire logic              SYS_CLK,
    input wire logic              RST_B,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic              CLK_PIN_OE,
    input wire logic              PORT_PINS_OWNED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    wire logic ctl = PSEL && PENABLE && PREADY && PADDR == '0;
    sequence setup_s; PSEL && !PENABLE; endsequence
    sequence wait_s; PSEL && PENABLE && !PREADY; endsequence
    ready_timing_a: assert property (setup_s |=> wait_s ##1 PREADY) else $error("ready timing");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready not a pulse");
    err_unmapped_a: assert property (PREADY && PADDR > 16 |-> PSLVERR) else $error("no slverr");
    err_mapped_a: assert property (PREADY && PADDR inside {0, 4, 8, 12, 16} |-> !PSLVERR)
        else $error("slverr on mapped");
    err_read_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 0) else $error("bad read data");
    ctl_upper_a: assert property (ctl && !PWRITE |-> PRDATA[31:8] == 0) else $error("upper bits set");
    owned_write_a: assert property (ctl && PWRITE |=> ##1 PORT_PINS_OWNED == $past(PWDATA[7], 2))
        else $error("owned not written");
    owned_read_a: assert property (ctl && !PWRITE |-> PRDATA[7] == PORT_PINS_OWNED)
        else $error("owned not enable");
    clk_oe_a: assert property (CLK_PIN_OE |-> PORT_PINS_OWNED) else $error("clock pin unowned");
endmodule
bind src_top src_properties #(.ADDR_W(ADDR_W)) chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CLK_PIN_OE(CLK_PIN_OE), .PORT_PINS_OWNED(PORT_PINS_OWNED));

// ===== dv/tb_top.sv
// Testbench: APB master, receive scenarios and verdict for src_top.
// Assumes divisor 0 and the transmitter model on the data pin.
`timescale 1ns/1ps
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, x, g); end end
module tb_top;
    logic        SYS_CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = '0;
    logic [31:0] PRDATA, r;
    logic        PREADY, PSLVERR, e, DATA_PIN_I, DATA_PIN_O, DATA_PIN_OE, CLK_PIN_O, CLK_PIN_OE;
    logic        PORT_PINS_OWNED, IRQ;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #2.5 SYS_CLK = ~SYS_CLK;
    src_top dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .DATA_PIN_I(DATA_PIN_I), .DATA_PIN_O(DATA_PIN_O), .DATA_PIN_OE(DATA_PIN_OE), .CLK_PIN_I(1'b0),
        .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE(CLK_PIN_OE), .PORT_PINS_OWNED(PORT_PINS_OWNED), .IRQ(IRQ));
    src_tx_model tx_u (.clk(SYS_CLK), .txd(DATA_PIN_I));
    task automatic complete_run;
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard: every scenario together needs far fewer cycles
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            complete_run;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rd(input logic [7:0] a); apb(1'b0, a, '0); endtask
    task automatic wait_irq;
        for (int k = 0; k < 90 && IRQ !== 1'b1; k++) @(negedge SYS_CLK);
        `CHK("irq", 1'b1, IRQ)
    endtask
    task automatic t_reset;
        rd(8'h00);
        `CHK("ctl", 7'h00, r[7:1])
        rd(8'h14);
        `CHK("slverr", 1'b1, e)
        `CHK("unmapped", 32'h0000_0000, r)
    endtask
    task automatic t_async;
        wr(8'h0c, 32'h0000_0007);
        wr(8'h00, 32'h0000_0098);
        tx_u.send(9'h0a5, 1'b0, 1'b1);
        wait_irq;
        rd(8'h04);
        `CHK("data8", 8'ha5, r[7:0])
        rd(8'h08);
        repeat (2) @(negedge SYS_CLK);
        `CHK("irq_clear", 1'b0, IRQ)
        wr(8'h00, 32'h0000_0080);
        tx_u.send(9'h03c, 1'b0, 1'b1);
        repeat (40) @(negedge SYS_CLK);
        `CHK("rx_off", 1'b0, IRQ)
    endtask
    task automatic t_nine;
        wr(8'h00, 32'h0000_00d8);
        tx_u.send(9'h055, 1'b1, 1'b1);
        repeat (40) @(negedge SYS_CLK);
        `CHK("dropped", 1'b0, IRQ)
        tx_u.send(9'h1aa, 1'b1, 1'b1);
        wait_irq;
        rd(8'h00);
        `CHK("ninth", 1'b1, r[0])
        rd(8'h04);
        rd(8'h08);
        wr(8'h00, 32'h0000_00d0);
        tx_u.send(9'h033, 1'b1, 1'b1);
        wait_irq;
        rd(8'h00);
        `CHK("ninth0", 1'b0, r[0])
        rd(8'h04);
        `CHK("data9", 8'h33, r[7:0])
        rd(8'h08);
    endtask
    task automatic t_errors;
        wr(8'h00, 32'h0000_0090);
        tx_u.send(9'h0f0, 1'b0, 1'b0);
        wait_irq;
        rd(8'h00);
        `CHK("framing", 1'b1, r[2])
        rd(8'h04);
        tx_u.send(9'h011, 1'b0, 1'b1);
        tx_u.send(9'h022, 1'b0, 1'b1);
        repeat (8) @(negedge SYS_CLK);
        rd(8'h00);
        `CHK("framing_new", 1'b0, r[2])
        `CHK("overrun", 1'b1, r[1])
        rd(8'h04);
        `CHK("kept", 8'h11, r[7:0])
        wr(8'h00, 32'h0000_0080);
        rd(8'h00);
        `CHK("overrun_clr", 1'b0, r[1])
        rd(8'h08);
    endtask
    task automatic t_sync;
        wr(8'h0c, '0);
        wr(8'h10, 32'h0003_0000);
        wr(8'h00, 32'h0000_00a0);
        repeat (60) @(negedge SYS_CLK);
        `CHK("masked", 1'b0, IRQ)
        rd(8'h00);
        `CHK("single_clr", 1'b0, r[5])
        rd(8'h04);
        `CHK("sync_data", 8'hff, r[7:0])
        rd(8'h08);
        `CHK("status", 1'b1, r[0])
        wr(8'h0c, 32'h0000_0007);
        wr(8'h00, 32'h0000_00b0);
        wait_irq;
        rd(8'h04);
        rd(8'h08);
        wait_irq;
        wr(8'h00, '0);
        repeat (2) @(negedge SYS_CLK);
        `CHK("released", 1'b0, PORT_PINS_OWNED)
        `CHK("clk_oe", 1'b0, CLK_PIN_OE)
        `CHK("data_oe", 1'b0, DATA_PIN_OE)
    endtask
    initial begin
        repeat (2) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        t_reset;
        t_async;
        t_nine;
        t_errors;
        t_sync;
        complete_run;
    end
endmodule
